// *** design/rotate_through_carry_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Right form rotates word plus carry toward LSB by n positions.
// RULE_02: Left form rotates word plus carry toward MSB by n positions.
// RULE_03: 16-bit forms use a 17-position loop: word plus carry.
// RULE_04: 32-bit forms use a 33-position loop: word plus carry.
// RULE_05: Issuer keeps n at most 16 (16-bit) or 32 (32-bit).
// RULE_06: Carry ends as the last bit moved out of the word's end.
// RULE_07: Old carry enters the loop and moves into the word.
// RULE_08: Continuous forms rotate again every cycle the condition holds.
// RULE_09: Pulse forms rotate once per false-to-true condition change.
// RULE_10: Issuer uses only four- or eight-digit bit groups as destination.
// RULE_11: Condition false leaves word and carry; state output shows run.
module rotate_through_carry_unit
   import rtcu_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             enable,
   input  wire logic [2:0]       opSel,
   input  wire logic [CNT_W-1:0] rotCount,
   input  wire logic [W32-1:0]   wordIn,
   input  wire logic             carryIn,
   output var  logic [W32-1:0]   wordOut,
   output var  logic             carry_flag,
   output var  logic             execution_state_out
);
   // =====================================================
   // Decode
   // =====================================================
   logic [W32-1:0] word_reg;
   logic           carry_reg;
   logic           ranLast_reg;
   logic           enPrev_reg;
   wire            isPulse = opSel[OP_PULSE_BIT];
   wire            isWide  = opSel[OP_WIDE_BIT];
   wire            isLeft  = opSel[OP_LEFT_BIT];
   wire            rise    = enable & ~enPrev_reg;
   // Pulse forms act on the rising edge only
   wire            doRun   = isPulse ? rise : enable; // RULE_08 RULE_09
   // Counts beyond the limit are the issuer's fault; clamp for safety
   wire [5:0]      nMax    = isWide ? MAX_N32 : MAX_N16; // RULE_05
   wire [5:0]      nRaw    = (rotCount > CNT_W'(nMax)) ? nMax
                                                       : rotCount[5:0];

   // =====================================================
   // Rotation loop
   // =====================================================
   // Loop holds carry at bit L, word below it; L is 16 or 32
   logic [LOOP_W-1:0] loopIn;
   logic [LOOP_W-1:0] loopOut;
   logic [W32-1:0]    wordRes;
   logic              carryRes;
   always_comb begin
      loopIn  = '0;
      loopOut = '0;
      if (isWide) begin
         loopIn = {carryIn, wordIn}; // RULE_04 RULE_07
         for (int i = 0; i < LOOP_W; i++) begin
            if (isLeft) begin
               loopOut[(i + int'(nRaw)) % LOOP_W] = loopIn[i]; // RULE_02
            end else begin
               loopOut[(i + LOOP_W - int'(nRaw)) % LOOP_W] =
                  loopIn[i]; // RULE_01
            end
         end
         wordRes  = loopOut[W32-1:0];
         carryRes = loopOut[W32]; // RULE_06
      end else begin
         loopIn[W16:0] = {carryIn, wordIn[W16-1:0]}; // RULE_03 RULE_07
         for (int i = 0; i <= W16; i++) begin
            if (isLeft) begin
               loopOut[(i + int'(nRaw)) % (W16 + 1)] = loopIn[i];
            end else begin
               loopOut[(i + W16 + 1 - int'(nRaw)) % (W16 + 1)] =
                  loopIn[i];
            end
         end
         // Upper half of the word passes untouched in 16-bit forms
         wordRes  = {wordIn[W32-1:W16], loopOut[W16-1:0]};
         carryRes = loopOut[W16]; // RULE_06
      end
   end

   // =====================================================
   // State
   // =====================================================
   // Tracked for every form, so a pulse op sees the true last level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         enPrev_reg <= 1'b0;
      end else begin
         enPrev_reg <= enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ranLast_reg <= 1'b0;
      end else begin
         ranLast_reg <= doRun; // RULE_11
      end
   end

   // No run, no write: word and carry keep the last result
   always_ff @(posedge clk) begin
      if (!resetn) begin
         word_reg  <= WORD_RST;
         carry_reg <= 1'b0;
      end else if (doRun) begin // RULE_11
         word_reg  <= wordRes;
         carry_reg <= carryRes;
      end
   end

   assign wordOut             = word_reg;
   assign carry_flag          = carry_reg;
   assign execution_state_out = ranLast_reg;

   // =====================================================
   // Checks
   // =====================================================
   AST_RESET_CLEAR: assert property (@(posedge clk)
      !resetn |=> wordOut == WORD_RST && !carry_flag
         && !execution_state_out) // RULE_11
      else $error("outputs not cleared by reset");

   AST_HOLD_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      !enable |=> $stable(word_reg) && $stable(carry_reg)) // RULE_11
      else $error("word or carry changed while idle");

   AST_STATE_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      !enable |=> !execution_state_out) // RULE_11
      else $error("state output high while idle");

   AST_CONT_RUN: assert property (@(posedge clk) disable iff (!resetn)
      enable && !isPulse |=> execution_state_out) // RULE_08
      else $error("continuous form skipped a cycle");

   AST_PULSE_ONCE: assert property (@(posedge clk) disable iff (!resetn)
      isPulse && enable && $past(enable) |=> !execution_state_out) // RULE_09
      else $error("pulse form ran while enable held");

   AST_PULSE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      isPulse && enable && enPrev_reg |=>
         $stable(word_reg) && $stable(carry_reg)) // RULE_09
      else $error("pulse form moved word while enable held");

   AST_PULSE_EDGE: assert property (@(posedge clk) disable iff (!resetn)
      isPulse && enable && !enPrev_reg |=> execution_state_out) // RULE_09
      else $error("pulse form missed rising edge");

   // Count of zero is a legal no-op: the loop comes back unchanged
   AST_ZERO_N: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h00 |=> wordOut == $past(wordIn)
         && carry_flag == $past(carryIn)) // RULE_07
      else $error("zero count altered loop");

   AST_R1_CARRY: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && !isLeft |=>
         carry_flag == $past(wordIn[0])) // RULE_01
      else $error("right rotate carry wrong");

   AST_R1_WORD16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && !isLeft && !isWide |=>
         wordOut[W16-1] == $past(carryIn)
         && wordOut[W16-2:0] == $past(wordIn[W16-1:1])) // RULE_01 RULE_07
      else $error("right 16-bit rotate word wrong");

   AST_R1_WORD32: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && !isLeft && isWide |=>
         wordOut[W32-1] == $past(carryIn)
         && wordOut[W32-2:0] == $past(wordIn[W32-1:1])) // RULE_01 RULE_04
      else $error("right 32-bit rotate word wrong");

   AST_L1_CARRY16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && isLeft && !isWide |=>
         carry_flag == $past(wordIn[W16-1])
         && wordOut[0] == $past(carryIn)) // RULE_02
      else $error("left 16-bit rotate wrong");

   AST_L1_WORD16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && isLeft && !isWide |=>
         wordOut[W16-1:1] == $past(wordIn[W16-2:0])) // RULE_02 RULE_07
      else $error("left 16-bit rotate word wrong");

   AST_L1_CARRY32: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && isLeft && isWide |=>
         carry_flag == $past(wordIn[W32-1])) // RULE_04
      else $error("left 32-bit rotate carry wrong");

   AST_L1_WORD32: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == 6'h01 && isLeft && isWide |=>
         wordOut == {$past(wordIn[W32-2:0]), $past(carryIn)}) // RULE_02
      else $error("left 32-bit rotate word wrong");

   // Full-length counts expose a loop one position short or long
   AST_FULL16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == MAX_N16 && !isLeft && !isWide |=>
         carry_flag == $past(wordIn[W16-1])
         && wordOut[0] == $past(carryIn)) // RULE_03
      else $error("16-bit loop length wrong");

   AST_FULL32: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == MAX_N32 && !isLeft && isWide |=>
         carry_flag == $past(wordIn[W32-1])
         && wordOut[0] == $past(carryIn)) // RULE_04
      else $error("32-bit loop length wrong");

   AST_LFULL16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == MAX_N16 && isLeft && !isWide |=>
         carry_flag == $past(wordIn[0])
         && wordOut[W16-1] == $past(carryIn)) // RULE_03
      else $error("16-bit left loop length wrong");

   AST_LFULL32: assert property (@(posedge clk) disable iff (!resetn)
      doRun && nRaw == MAX_N32 && isLeft && isWide |=>
         carry_flag == $past(wordIn[0])
         && wordOut[W32-1] == $past(carryIn)) // RULE_04
      else $error("32-bit left loop length wrong");

   // Upper half must survive 16-bit forms untouched
   AST_UPPER16: assert property (@(posedge clk) disable iff (!resetn)
      doRun && !isWide |=>
         wordOut[W32-1:W16] == $past(wordIn[W32-1:W16])) // RULE_03
      else $error("16-bit form disturbed upper half");
endmodule
`default_nettype wire

// *** design/rtcu_pkg.sv ***
`default_nettype none
package rtcu_pkg;
   // =====================================================
   // Widths and limits
   // =====================================================
   localparam int unsigned W16       = 16;
   localparam int unsigned W32       = 32;
   localparam int unsigned CNT_W     = 16;
   localparam int unsigned LOOP_W    = W32 + 1;
   localparam logic [5:0]  MAX_N16   = 6'h10;
   localparam logic [5:0]  MAX_N32   = 6'h20;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;

   // =====================================================
   // Operation select
   // =====================================================
   typedef enum logic [2:0] {
      rotate_right_carry_cont16  = 3'b000,
      rotate_right_carry_pulse16 = 3'b001,
      rotate_right_carry_cont32  = 3'b010,
      rotate_right_carry_pulse32 = 3'b011,
      rotate_left_carry_cont16   = 3'b100,
      rotate_left_carry_pulse16  = 3'b101,
      rotate_left_carry_cont32   = 3'b110,
      rotate_left_carry_pulse32  = 3'b111
   } rtcu_op_t;

   localparam int unsigned OP_PULSE_BIT = 0;
   localparam int unsigned OP_WIDE_BIT  = 1;
   localparam int unsigned OP_LEFT_BIT  = 2;
endpackage
`default_nettype wire

// *** bench/test_rotate_through_carry_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Stimulus and checking
// =====================================================
module test_rotate_through_carry_unit import rtcu_pkg::*; ;
   logic        clk = 1'b0, resetn = 1'b0, enable = 1'b0, carryIn = 1'b0;
   logic [2:0]  opSel    = 3'h0;
   logic [15:0] rotCount = 16'h0000;
   logic [31:0] wordIn   = 32'h0000_0000;
   logic [31:0] wordOut;
   logic        carry_flag, execution_state_out;
   int          err_count = 0, checked = 0;
   rotate_through_carry_unit u_dut (.clk(clk), .resetn(resetn),
      .enable(enable), .opSel(opSel), .rotCount(rotCount), .wordIn(wordIn),
      .carryIn(carryIn), .wordOut(wordOut), .carry_flag(carry_flag),
      .execution_state_out(execution_state_out));
   always #25 clk = ~clk;
   task automatic final_report;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [32:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One step at a time around the word plus carry loop
   function automatic logic [32:0] model(input logic [2:0] op, input int n,
                                         input logic [31:0] w, input logic c);
      logic [31:0] ww;
      logic        cc;
      logic        t;
      int          wd;
      ww = w;
      cc = c;
      wd = op[1] ? 32 : 16;
      for (int i = 0; i < n; i++) begin
         t = op[2] ? ww[wd-1] : ww[0];
         if (op[2]) begin
            ww = {ww[30:0], cc};
         end else begin
            ww = ww >> 1;
            ww[wd-1] = cc;
         end
         cc = t;
      end
      if (!op[1]) begin
         ww[31:16] = w[31:16];
      end
      return {cc, ww};
   endfunction
   task automatic op_once(input logic [2:0] op, input int n,
                          input logic [31:0] w, input logic c);
      logic [32:0] e;
      e = model(op, n, w, c);
      @(negedge clk);
      opSel    = op;
      rotCount = n[15:0];
      wordIn   = w;
      carryIn  = c;
      enable   = 1'b1;
      @(negedge clk);
      chk("result", {carry_flag, wordOut}, e);
      chk("carry", {32'h0, carry_flag}, 33'(e[32]));
      chk("state", 33'(execution_state_out), 33'h1);
      enable  = 1'b0;
      wordIn  = ~w;
      carryIn = ~c;
      @(negedge clk);
      chk("idle state", 33'(execution_state_out), 33'h0);
      chk("idle hold", {carry_flag, wordOut}, e);
   endtask
   // Whole 16- or 32-bit words only, counts never above the width
   task automatic t_table;
      int ns[4] = '{0, 1, 5, 16};
      for (int op = 0; op < 8; op++) begin
         for (int k = 0; k < 8; k++) begin
            op_once(op[2:0], (k / 2 == 3 && op[1]) ? 32 : ns[k/2],
                    32'hA5C3_0F91, k[0]);
         end
      end
   endtask
   task automatic t_cont;
      logic [32:0] e;
      e = {1'b1, 32'h1234_5678};
      @(negedge clk);
      opSel    = rotate_left_carry_cont32;
      rotCount = 16'h0003;
      enable   = 1'b1;
      for (int i = 0; i < 3; i++) begin
         wordIn  = e[31:0];
         carryIn = e[32];
         e       = model(opSel, 3, e[31:0], e[32]);
         @(negedge clk);
         chk("cont result", {carry_flag, wordOut}, e);
         chk("cont state", 33'(execution_state_out), 33'h1);
      end
      enable = 1'b0;
   endtask
   task automatic t_pulse;
      logic [32:0] e;
      e = model(rotate_right_carry_pulse16, 4, 32'hFFFF_0F0F, 1'b0);
      @(negedge clk);
      opSel    = rotate_right_carry_pulse16;
      rotCount = 16'h0004;
      wordIn   = 32'hFFFF_0F0F;
      carryIn  = 1'b0;
      enable   = 1'b1;
      @(negedge clk);
      chk("pulse result", {carry_flag, wordOut}, e);
      chk("pulse run", 33'(execution_state_out), 33'h1);
      for (int i = 0; i < 2; i++) begin
         wordIn = 32'h0000_1111 << i;
         @(negedge clk);
         chk("pulse hold", {carry_flag, wordOut}, e);
         chk("pulse state", 33'(execution_state_out), 33'h0);
      end
      enable = 1'b0;
      @(negedge clk);
   endtask
   initial begin
      #100000;
      err_count++;
      final_report;
   end
   initial begin
      repeat (20) @(negedge clk);
      chk("reset", {carry_flag, wordOut}, 33'h0);
      chk("reset state", 33'(execution_state_out), 33'h0);
      resetn = 1'b1;
      t_table;
      t_cont;
      t_pulse;
      final_report;
   end
endmodule
`default_nettype wire
